// file: hw/dcf_device_ctrl.sv
// device control feature registers behind an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none

module dcf_device_ctrl
   import dcf_pkg::*;
#(
   parameter logic [31:0] PEAK_BW       = PEAK_BW_DEF,
   parameter bit          SCAN_WRITABLE = 1'b1
)(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [ADDR_W-1:0] avsAddress,
   input  wire logic              avsRead,
   input  wire logic              avsWrite,
   input  wire logic [31:0]       avsWritedata,
   input  wire logic [3:0]        avsByteenable,
   output logic      [31:0]       avsReaddata,
   output logic                   avsWaitrequest,
   input  wire logic              beginLocked,
   input  wire dcf_temps_s        temps,
   input  wire dcf_clocks_s       clocks,
   output dcf_cfg_s               activeCfg,
   output logic                   bulkActive,
   output logic                   regsetValid
);

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            res[8*i +: 8] = wd[8*i +: 8];
      return res;
   endfunction : mergeBytes

   function automatic logic rateOk(input logic [RATE_W-1:0] r);
      return r <= BAUD_CUSTOM;
   endfunction : rateOk

   function automatic logic setOk(input logic [1:0] th, input logic [PORT_CNT-1:0][RATE_W-1:0] rs);
      logic ok;
      ok = (th <= TH_CUSTOM);
      for (int i = 0; i < PORT_CNT; i++)
         ok = ok & rateOk(rs[i]);
      return ok;
   endfunction : setOk

   logic                            ackR;
   logic                            restoreR;
   logic                            softRst;
   logic [1:0]                      thermSelR;
   logic [1:0]                      clockSelR;
   logic [PORT_W-1:0]               portSelR;
   logic [PORT_CNT-1:0][RATE_W-1:0] rateR;
   logic                            scanLineR;
   logic                            bulkR;
   logic                            validR;
   dcf_cfg_s                        activeR;
   logic                            wrAcc;
   logic [31:0]                     wdm;
   logic [31:0]                     rdNxt;
   logic                            consistent;
   logic                            cmdBegin;
   logic                            cmdEnd;
   logic                            cmdCheck;
   logic                            cmdRestore;

   // one wait cycle per access; a write is taken at the edge where waitrequest is low, read data is loaded at the wait edge before it
   assign avsWaitrequest = (avsRead | avsWrite) & ~ackR;
   assign wrAcc          = avsWrite & ackR;
   assign softRst        = reset | restoreR;
   assign consistent     = setOk(thermSelR, rateR);

   always_ff @(posedge clk)
   begin
      if (reset)
         ackR <= 1'b0;
      else
         ackR <= (avsRead | avsWrite) & ~ackR;
   end

   always_comb
   begin
      case (avsAddress)
         OFS_THERM_SEL: wdm = mergeBytes({30'h0, thermSelR}, avsWritedata, avsByteenable);
         OFS_CLOCK_SEL: wdm = mergeBytes({30'h0, clockSelR}, avsWritedata, avsByteenable);
         OFS_PORT_SEL:  wdm = mergeBytes({{(32-PORT_W){1'b0}}, portSelR}, avsWritedata, avsByteenable);
         OFS_PORT_RATE: wdm = mergeBytes({28'h0, rateR[portSelR]}, avsWritedata, avsByteenable);
         OFS_SCAN:      wdm = mergeBytes({31'h0, scanLineR}, avsWritedata, avsByteenable);
         default:       wdm = avsByteenable[0] ? avsWritedata : 32'h0;
      endcase
   end

   // commands are one-cycle strobes and never stored
   assign cmdRestore = wrAcc & (avsAddress == OFS_COMMAND) & wdm[CMD_RESTORE];
   assign cmdBegin   = wrAcc & (avsAddress == OFS_COMMAND) & wdm[CMD_BEGIN] & ~beginLocked;
   assign cmdEnd     = wrAcc & (avsAddress == OFS_COMMAND) & wdm[CMD_END];
   assign cmdCheck   = wrAcc & (avsAddress == OFS_COMMAND) & wdm[CMD_CHECK];

   // restore takes effect on the following edge, like a reset pulse
   always_ff @(posedge clk)
   begin
      if (softRst)
         restoreR <= 1'b0;
      else
         restoreR <= cmdRestore;
   end

   // writes outside the legal range are dropped, except scan writes, which take bit 0; in bulk mode thermal point and baud rate writes are taken unchecked
   always_ff @(posedge clk)
   begin
      if (softRst)
      begin
         thermSelR <= RST_THERM_SEL;
         clockSelR <= RST_CLOCK_SEL;
         portSelR  <= '0;
         rateR     <= {PORT_CNT{RST_RATE}};
         scanLineR <= RST_SCAN_LINE;
      end
      else if (wrAcc)
      begin
         case (avsAddress)
            OFS_THERM_SEL:
               if (bulkR || wdm[31:0] <= {30'h0, TH_CUSTOM})
                  thermSelR <= wdm[1:0];
            OFS_CLOCK_SEL:
               if (wdm[31:2] == 30'h0)
                  clockSelR <= wdm[1:0];
            OFS_PORT_SEL:
               if (wdm < PORT_CNT)
                  portSelR <= wdm[PORT_W-1:0];
            OFS_PORT_RATE:
               if (bulkR || (wdm[31:RATE_W] == '0 && rateOk(wdm[RATE_W-1:0])))
                  rateR[portSelR] <= wdm[RATE_W-1:0];
            OFS_SCAN:
               if (SCAN_WRITABLE)
                  scanLineR <= wdm[0];
            default:
               ;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (softRst)
         bulkR <= 1'b0;
      else if (cmdEnd)
         bulkR <= 1'b0;
      else if (cmdBegin)
         bulkR <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (softRst)
         validR <= RST_VALID;
      else if (cmdEnd || cmdCheck)
         validR <= consistent;
   end

   // outside bulk mode a consistent set is live; in bulk mode it goes live only at a consistent end
   always_ff @(posedge clk)
   begin
      if (softRst)
      begin
         activeR.thermSel <= RST_THERM_SEL;
         activeR.clockSel <= RST_CLOCK_SEL;
         activeR.scanLine <= RST_SCAN_LINE;
         activeR.rates    <= {PORT_CNT{RST_RATE}};
      end
      else if ((!bulkR || cmdEnd) && consistent)
      begin
         activeR.thermSel <= thermSelR;
         activeR.clockSel <= clockSelR;
         activeR.scanLine <= scanLineR;
         activeR.rates    <= rateR;
      end
   end

   always_comb
   begin
      case (avsAddress)
         OFS_COMMAND:    rdNxt = 32'h0;
         OFS_STATUS:     rdNxt = {29'h0, beginLocked, bulkR, validR};
         OFS_PEAK_BW:    rdNxt = (PEAK_BW == 32'h0) ? 32'h1 : PEAK_BW;
         OFS_THERM_SEL:  rdNxt = {30'h0, thermSelR};
         OFS_THERM_READ:
            case (activeR.thermSel)
               TH_SENSOR: rdNxt = {{16{temps.sensorTemp[15]}}, temps.sensorTemp};
               TH_BOARD:  rdNxt = {{16{temps.boardTemp[15]}}, temps.boardTemp};
               default:   rdNxt = {{16{temps.customTemp[15]}}, temps.customTemp};
            endcase
         OFS_CLOCK_SEL:  rdNxt = {30'h0, clockSelR};
         OFS_CLOCK_HZ:
            case (clockSelR)
               CK_SENSOR: rdNxt = clocks.sensorHz;
               CK_ADC:    rdNxt = clocks.adcHz;
               CK_LINK:   rdNxt = clocks.linkHz;
               default:   rdNxt = clocks.customHz;
            endcase
         OFS_PORT_SEL:   rdNxt = {{(32-PORT_W){1'b0}}, portSelR};
         OFS_PORT_RATE:  rdNxt = {28'h0, rateR[portSelR]};
         OFS_SCAN:       rdNxt = {31'h0, scanLineR};
         default:        rdNxt = 32'h0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         avsReaddata <= 32'h0;
      else if (avsRead && !ackR)
         avsReaddata <= rdNxt;
   end

   assign activeCfg   = activeR;
   assign bulkActive  = bulkR;
   assign regsetValid = validR;

   sequence s_cmd_write(int b);
      wrAcc && avsAddress == OFS_COMMAND && wdm[b];
   endsequence

   sequence s_restored;
      thermSelR == RST_THERM_SEL && !bulkR && validR == RST_VALID && rateR[0] == RST_RATE && !restoreR;
   endsequence

   a_bus_one_wait: assert property (@(posedge clk) disable iff (reset)
      $rose(avsRead | avsWrite) |-> avsWaitrequest ##1 !avsWaitrequest)
      else $error("access not answered after one wait cycle");

   a_restore_power_up: assert property (@(posedge clk) disable iff (reset)
      s_cmd_write(CMD_RESTORE) |=> restoreR ##1 s_restored)
      else $error("restore did not return power-up state");

   a_begin_enters_bulk: assert property (@(posedge clk) disable iff (reset)
      s_cmd_write(CMD_BEGIN) and (!beginLocked && !wdm[CMD_END] && !wdm[CMD_RESTORE]) |=> bulkR)
      else $error("begin did not enter bulk mode");

   a_begin_lock_holds: assert property (@(posedge clk) disable iff (reset || restoreR)
      s_cmd_write(CMD_BEGIN) and (beginLocked && !bulkR && !wdm[CMD_RESTORE]) |=> !bulkR)
      else $error("locked begin entered bulk mode");

   a_end_validates: assert property (@(posedge clk) disable iff (reset)
      s_cmd_write(CMD_END) and (!wdm[CMD_RESTORE] && consistent)
      |=> !bulkR && validR && activeR.rates == $past(rateR))
      else $error("end did not activate the consistent set");

   a_end_flag_result: assert property (@(posedge clk) disable iff (reset)
      s_cmd_write(CMD_END) and !wdm[CMD_RESTORE] |=> validR == $past(consistent))
      else $error("end did not load validity flag");

   a_check_flag_result: assert property (@(posedge clk) disable iff (reset)
      s_cmd_write(CMD_CHECK) and !wdm[CMD_RESTORE] |=> validR == $past(consistent) && bulkR == $past(bulkR))
      else $error("check did not load validity flag");

   a_flag_only_by_cmd: assert property (@(posedge clk) disable iff (reset)
      !cmdEnd && !cmdCheck && !restoreR |=> validR == $past(validR))
      else $error("validity flag changed without a command");

   a_peak_nonzero: assert property (@(posedge clk) disable iff (reset)
      avsRead && !ackR && avsAddress == OFS_PEAK_BW |=> avsReaddata != 32'h0)
      else $error("peak bandwidth read as zero");

   a_range_reject: assert property (@(posedge clk) disable iff (reset)
      wrAcc && avsAddress == OFS_PORT_RATE && !bulkR && wdm > BAUD_CUSTOM && !restoreR
      |=> rateR == $past(rateR))
      else $error("out-of-range baud entry accepted outside bulk mode");

   a_cmd_reads_idle: assert property (@(posedge clk) disable iff (reset)
      avsRead && !ackR && avsAddress == OFS_COMMAND |=> avsReaddata == 32'h0 && !avsWaitrequest)
      else $error("command register did not read idle");

   a_bulk_freezes_set: assert property (@(posedge clk) disable iff (reset)
      bulkR && !cmdEnd && !restoreR |=> activeR == $past(activeR))
      else $error("active set changed during bulk mode");

   a_therm_refuse: assert property (@(posedge clk) disable iff (reset)
      wrAcc && avsAddress == OFS_THERM_SEL && !bulkR && wdm > {30'h0, TH_CUSTOM} && !restoreR
      |=> thermSelR == $past(thermSelR))
      else $error("out-of-range thermal point accepted outside bulk mode");

   a_scan_switch: assert property (@(posedge clk) disable iff (reset)
      SCAN_WRITABLE && wrAcc && avsAddress == OFS_SCAN && !restoreR |=> scanLineR == $past(wdm[0]))
      else $error("scan geometry write not taken");

endmodule : dcf_device_ctrl

`default_nettype wire

// file: inc/dcf_pkg.sv
// register map, field layout, reset values and carrier types of the device control feature block
package dcf_pkg;
   localparam int          ADDR_W         = 8;
   localparam int          PORT_CNT       = 2;
   localparam int          PORT_W         = 1;
   localparam int          RATE_W         = 4;
   localparam int          CLK_MHZ        = 50;
   // byte addresses, one aligned word each
   localparam logic [7:0]  OFS_COMMAND    = 8'h00;
   localparam logic [7:0]  OFS_STATUS     = 8'h04;
   localparam logic [7:0]  OFS_PEAK_BW    = 8'h08;
   localparam logic [7:0]  OFS_THERM_SEL  = 8'h0c;
   localparam logic [7:0]  OFS_THERM_READ = 8'h10;
   localparam logic [7:0]  OFS_CLOCK_SEL  = 8'h14;
   localparam logic [7:0]  OFS_CLOCK_HZ   = 8'h18;
   localparam logic [7:0]  OFS_PORT_SEL   = 8'h1c;
   localparam logic [7:0]  OFS_PORT_RATE  = 8'h20;
   localparam logic [7:0]  OFS_SCAN       = 8'h24;
   // command bits
   localparam int          CMD_RESTORE    = 0;
   localparam int          CMD_BEGIN      = 1;
   localparam int          CMD_END        = 2;
   localparam int          CMD_CHECK      = 3;
   // status bits
   localparam int          ST_VALID       = 0;
   localparam int          ST_BULK        = 1;
   localparam int          ST_LOCKED      = 2;
   // thermal points
   localparam logic [1:0]  TH_SENSOR      = 2'h0;
   localparam logic [1:0]  TH_BOARD       = 2'h1;
   localparam logic [1:0]  TH_CUSTOM      = 2'h2;
   // clock sources
   localparam logic [1:0]  CK_SENSOR      = 2'h0;
   localparam logic [1:0]  CK_ADC         = 2'h1;
   localparam logic [1:0]  CK_LINK        = 2'h2;
   localparam logic [1:0]  CK_CUSTOM      = 2'h3;
   // baud rate entries; the last one stands for the non-standard rate
   typedef enum logic [3:0] {
      BAUD_9600   = 4'h0,
      BAUD_19200  = 4'h1,
      BAUD_38400  = 4'h2,
      BAUD_57600  = 4'h3,
      BAUD_115200 = 4'h4,
      BAUD_230400 = 4'h5,
      BAUD_460800 = 4'h6,
      BAUD_921600 = 4'h7,
      BAUD_CUSTOM = 4'h8
   } dcf_baud_e;
   // reset values
   localparam logic [1:0]  RST_THERM_SEL  = TH_SENSOR;
   localparam logic [1:0]  RST_CLOCK_SEL  = CK_SENSOR;
   localparam logic [3:0]  RST_RATE       = BAUD_115200;
   localparam logic        RST_SCAN_LINE  = 1'b0;
   localparam logic        RST_VALID      = 1'b1;
   localparam logic [31:0] PEAK_BW_DEF    = 32'h05f5e100;
   // measured values supplied by the rest of the camera
   typedef struct packed {
      logic [15:0] sensorTemp;
      logic [15:0] boardTemp;
      logic [15:0] customTemp;
   } dcf_temps_s;
   typedef struct packed {
      logic [31:0] sensorHz;
      logic [31:0] adcHz;
      logic [31:0] linkHz;
      logic [31:0] customHz;
   } dcf_clocks_s;
   // active configuration driven to the camera
   typedef struct packed {
      logic [1:0]                      thermSel;
      logic [1:0]                      clockSel;
      logic                            scanLine;
      logic [PORT_CNT-1:0][RATE_W-1:0] rates;
   } dcf_cfg_s;
endpackage : dcf_pkg

// file: verif/dcf_device_ctrl_tb.sv
// self-checking bench for the device control feature registers
`timescale 1ns/1ps
`default_nettype none
module dcf_device_ctrl_tb
   import dcf_pkg::*;
;
   logic              clk            = 1'b0;
   logic              reset          = 1'b1;
   logic [ADDR_W-1:0] avsAddress     = '0;
   logic              avsRead        = 1'b0;
   logic              avsWrite       = 1'b0;
   logic [31:0]       avsWritedata   = '0;
   logic [3:0]        avsByteenable  = 4'hf;
   logic [31:0]       avsReaddata;
   logic              avsWaitrequest;
   logic              beginLocked    = 1'b0;
   logic [15:0]       tv [3]         = '{16'h0019, 16'hfff6, 16'h0030};
   logic [31:0]       cv [4]         = '{32'h0a000001, 32'h0b000002, 32'h0c000003, 32'h0d000004};
   dcf_temps_s        temps          = '{16'h0019, 16'hfff6, 16'h0030};
   dcf_clocks_s       clocks         = '{32'h0a000001, 32'h0b000002, 32'h0c000003, 32'h0d000004};
   dcf_cfg_s          activeCfg;
   logic              bulkActive;
   logic              regsetValid;
   int                errorCnt       = 0;
   int                nChecks        = 0;
   int                cycles         = 0;

   dcf_device_ctrl DUT (
      .clk            (clk),
      .reset          (reset),
      .avsAddress     (avsAddress),
      .avsRead        (avsRead),
      .avsWrite       (avsWrite),
      .avsWritedata   (avsWritedata),
      .avsByteenable  (avsByteenable),
      .avsReaddata    (avsReaddata),
      .avsWaitrequest (avsWaitrequest),
      .beginLocked    (beginLocked),
      .temps          (temps),
      .clocks         (clocks),
      .activeCfg      (activeCfg),
      .bulkActive     (bulkActive),
      .regsetValid    (regsetValid)
   );

   always #10 clk = ~clk;

   task automatic tally_and_finish;
      if (errorCnt == 0 && nChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // a hung handshake ends here
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errorCnt++;
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // request held until waitrequest is seen low at a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
      @(posedge clk);
      avsAddress    <= a;
      avsWritedata  <= d;
      avsByteenable <= be;
      avsWrite      <= 1'b1;
      do @(posedge clk); while (avsWaitrequest !== 1'b0);
      avsWrite <= 1'b0;
   endtask : wr

   task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      @(posedge clk);
      avsAddress <= a;
      avsRead    <= 1'b1;
      do @(posedge clk); while (avsWaitrequest !== 1'b0);
      d = avsReaddata;
      avsRead <= 1'b0;
      chk(what, d, exp);
   endtask : rc

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : wt

   initial
   begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk("activeCfg", 32'(activeCfg), 32'h0044);
      chk("bulkActive", 32'(bulkActive), 32'h0);
      chk("regsetValid", 32'(regsetValid), 32'h1);
      rc("status", OFS_STATUS, 32'h1);
      rc("command", OFS_COMMAND, 32'h0);
      rc("peak bw", OFS_PEAK_BW, 32'h05f5e100);
      wr(8'h28, 32'hffffffff);
      rc("unmapped", 8'h28, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         wr(OFS_THERM_SEL, 32'(i));
         rc("therm sel", OFS_THERM_SEL, 32'(i));
         rc("therm read", OFS_THERM_READ, {{16{tv[i][15]}}, tv[i]});
      end
      wr(OFS_THERM_SEL, 32'h3);
      rc("therm sel range", OFS_THERM_SEL, 32'h2);
      wr(OFS_THERM_SEL, 32'h1, 4'h0);
      rc("therm sel lanes", OFS_THERM_SEL, 32'h2);
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_CLOCK_SEL, 32'(i));
         rc("clock sel", OFS_CLOCK_SEL, 32'(i));
         rc("clock hz", OFS_CLOCK_HZ, cv[i]);
      end
      wr(OFS_CLOCK_SEL, 32'h4);
      rc("clock sel range", OFS_CLOCK_SEL, 32'h3);
      for (int p = 0; p < PORT_CNT; p++)
      begin
         wr(OFS_PORT_SEL, 32'(p));
         rc("port sel", OFS_PORT_SEL, 32'(p));
         for (int r = 0; r < 9; r++)
         begin
            wr(OFS_PORT_RATE, 32'(r));
            rc("port rate", OFS_PORT_RATE, 32'(r));
         end
         wr(OFS_PORT_RATE, 32'h9);
         rc("port rate range", OFS_PORT_RATE, 32'h8);
      end
      wr(OFS_PORT_SEL, 32'h2);
      rc("port sel range", OFS_PORT_SEL, 32'h1);
      wr(OFS_SCAN, 32'h1);
      rc("scan", OFS_SCAN, 32'h1);
      wr(OFS_STATUS, 32'h0);
      rc("status ro", OFS_STATUS, 32'h1);
      wr(OFS_PEAK_BW, 32'h0);
      rc("peak bw ro", OFS_PEAK_BW, 32'h05f5e100);
      wt(1);
      chk("activeCfg live", 32'(activeCfg), 32'h1788);
      // begin while locked must leave bulk mode off
      @(posedge clk);
      beginLocked <= 1'b1;
      wr(OFS_COMMAND, 32'h2);
      wt(1);
      chk("bulk locked", 32'(bulkActive), 32'h0);
      rc("status locked", OFS_STATUS, 32'h5);
      @(posedge clk);
      beginLocked <= 1'b0;
      wr(OFS_COMMAND, 32'h2);
      wt(1);
      chk("bulk on", 32'(bulkActive), 32'h1);
      rc("status bulk", OFS_STATUS, 32'h3);
      rc("command idle", OFS_COMMAND, 32'h0);
      wr(OFS_THERM_SEL, 32'h3);
      rc("therm sel bulk", OFS_THERM_SEL, 32'h3);
      wr(OFS_PORT_RATE, 32'h4);
      wt(1);
      chk("activeCfg frozen", 32'(activeCfg), 32'h1788);
      wr(OFS_COMMAND, 32'h8);
      wt(1);
      chk("valid after check", 32'(regsetValid), 32'h0);
      chk("bulk after check", 32'(bulkActive), 32'h1);
      wr(OFS_COMMAND, 32'h4);
      wt(1);
      chk("bulk after end", 32'(bulkActive), 32'h0);
      chk("valid after end", 32'(regsetValid), 32'h0);
      rc("status bad set", OFS_STATUS, 32'h0);
      wr(OFS_THERM_SEL, 32'h1);
      wr(OFS_COMMAND, 32'h8);
      wt(1);
      chk("valid recheck", 32'(regsetValid), 32'h1);
      wr(OFS_COMMAND, 32'h2);
      wr(OFS_THERM_SEL, 32'h0);
      wt(1);
      chk("activeCfg held", 32'(activeCfg), 32'h0f48);
      wr(OFS_COMMAND, 32'h4);
      wt(1);
      chk("activeCfg loaded", 32'(activeCfg), 32'h0748);
      chk("valid good end", 32'(regsetValid), 32'h1);
      // restore while in bulk mode
      wr(OFS_COMMAND, 32'h2);
      wr(OFS_COMMAND, 32'h1);
      wt(2);
      chk("activeCfg restore", 32'(activeCfg), 32'h0044);
      chk("bulk restore", 32'(bulkActive), 32'h0);
      chk("valid restore", 32'(regsetValid), 32'h1);
      rc("clock sel restore", OFS_CLOCK_SEL, 32'h0);
      rc("scan restore", OFS_SCAN, 32'h0);
      rc("port sel restore", OFS_PORT_SEL, 32'h0);
      rc("port rate restore", OFS_PORT_RATE, 32'h4);
      rc("command restore", OFS_COMMAND, 32'h0);
      tally_and_finish();
   end
endmodule : dcf_device_ctrl_tb
`default_nettype wire
